// File: core/sms_pkg.sv
package sms_pkg;

  // system clock figures
  localparam int SMS_CLK_PERIOD_NS = 5;
  localparam int SMS_CLK_FREQ_MHZ  = 200;

  // divisor register width and its value after reset
  localparam int         SMS_DIV_W     = 8;
  localparam logic [7:0] SMS_DIV_RESET = 8'h00;

  // system clocks per bit are this factor times (divisor + 1)
  localparam int SMS_CLKS_PER_BIT_FACTOR = 4;
  // divider ticks per half bit (clock high or clock low)
  localparam int SMS_TICKS_PER_HALF      = SMS_CLKS_PER_BIT_FACTOR / 2;

  // character lengths on the line
  localparam logic [3:0] SMS_BITS_EIGHT = 4'h8;
  localparam logic [3:0] SMS_BITS_NINE  = 4'h9;
  localparam int         SMS_CHAR_W     = 9;

  // idle level of the shift clock between characters, and the data level loaded at reset
  localparam logic SMS_CLK_IDLE  = 1'b0;
  localparam logic SMS_DATA_IDLE = 1'b0;

  // configuration bits presented as plain ports
  typedef struct packed {
    logic                 port_enable;
    logic                 sync_mode;
    logic                 clock_source_master_select;
    logic                 single_receive_enable;
    logic                 continuous_receive_enable;
    logic                 high_speed_rate_select;
    logic                 nine_bit_transmit_enable;
    logic                 transmit_ninth_bit;
    logic [SMS_DIV_W-1:0] rate_divisor;
  } sms_cfg_s;

  // one two-way pin seen from the design: level to drive and its enable
  typedef struct packed {
    logic level;
    logic oe;
  } sms_pin_s;

  typedef enum logic [0:0] {
    SMS_IDLE,
    SMS_SHIFT
  } sms_state_e;

  // complete state of the transmitter
  typedef struct packed {
    sms_state_e            state;
    logic [SMS_CHAR_W-1:0] hold_data;
    logic                  hold_nine;
    logic                  hold_full;
    logic [SMS_CHAR_W-1:0] shift_data;
    logic [3:0]            bits_left;
    logic                  sub_tick;
    logic                  clk_level;
    logic                  data_level;
    logic                  clk_oe;
    logic                  data_oe;
  } sms_tx_s;

  localparam sms_tx_s SMS_TX_RESET = '{
    state:      SMS_IDLE,
    hold_data:  9'h000,
    hold_nine:  1'b0,
    hold_full:  1'b0,
    shift_data: 9'h000,
    bits_left:  4'h0,
    sub_tick:   1'b0,
    clk_level:  SMS_CLK_IDLE,
    data_level: SMS_DATA_IDLE,
    clk_oe:     1'b0,
    data_oe:    1'b0
  };

endpackage

// File: core/sms_rate_gen.sv
`timescale 1ns/1ps
module sms_rate_gen
  import sms_pkg::*;
#(
  parameter int DIV_W = SMS_DIV_W
)(
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_run,
  input  wire logic [DIV_W-1:0] i_divisor,
  output logic                  o_tick
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } sms_gen_s;

  sms_gen_s q;
  sms_gen_s d;

  // one tick every divisor+1 clocks; four ticks make one bit [RULE18]
  // the counter restarts whenever the shifter stops, so each character starts on a full period
  always_comb
  begin
    d      = q;
    d.tick = 1'b0;
    if (!i_run)
    begin
      d.cnt = '0;
    end
    else if (q.cnt >= i_divisor)
    begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end
    else
    begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      q <= '0;
    else
      q <= d;
  end

  assign o_tick = q.tick;

endmodule

// File: core/sms_sync_tx.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1 - link uses one two-way data line and one clock line; master drives the clock
// RULE2 - shared data line, so half-duplex: never transmit while reception is configured
// RULE3 - no start or stop bits; only data bits reach the line
// RULE4 - clocked mode select high switches the port to synchronous clocked operation
// RULE5 - clock source master select high makes this end generate the shift clock
// RULE6 - both receive enables low means transmit; either high means reception
// RULE7 - port enable low keeps the whole port inactive and reset
// RULE8 - clock pin driver turns on whenever synchronous transmit or receive is configured; here only with clock source master select high
// RULE9 - data changes on the leading clock edge, stable at the trailing sample edge
// RULE10 - exactly one clock per data bit, no extra clocks
// RULE11 - master transmit drives the data pin; data and clock drivers enable automatically
// RULE12 - writing the holding register starts a transmission, nothing else needed
// RULE13 - new character waits in holding register until previous last bit is sent
// RULE14 - with the shift register empty the holding register loads without delay
// RULE15 - shifting starts right after the load into the shift register
// RULE16 - each bit changes on a leading edge and holds until the next one
// RULE17 - shift register is not visible to software; only the holding register is
// RULE18 - bit rate is clock over four times divisor plus one; high-speed select ignored
// RULE19 - nine-bit mode sends the ninth bit, latched with the holding register write
// RULE20 - characters go out least significant bit first
// RULE21 - clock stays idle between characters, no pulses while the shifter is empty
module sms_sync_tx
  import sms_pkg::*;
#(
  parameter int DIV_W = SMS_DIV_W
)(
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  input  wire sms_cfg_s   i_cfg,
  input  wire logic       i_hold_write,
  input  wire logic [7:0] i_hold_data,
  input  wire logic       i_clock_line_in,
  input  wire logic       i_data_line_in,
  output sms_pin_s        o_clock_line,
  output sms_pin_s        o_data_line,
  output logic            o_hold_full,
  output logic            o_shift_empty
);

  sms_tx_s q;
  sms_tx_s d;

  logic master_sync;
  logic tx_mode;
  logic rx_mode;
  logic may_send;
  logic gen_run;
  logic tick;
  logic half_edge;
  logic unused_pins;

  // number of bits in a character for the chosen length
  function automatic logic [3:0] char_bits(input logic nine);
    return nine ? SMS_BITS_NINE : SMS_BITS_EIGHT; // [RULE19]
  endfunction

  // move the holding register into the shifter and raise the first leading edge
  function automatic sms_tx_s load_char(input sms_tx_s s);
    sms_tx_s r;
    r            = s;
    r.shift_data = s.hold_data;                   // [RULE14]
    r.data_level = s.hold_data[0];                // first bit is the lsb [RULE20]
    r.clk_level  = ~SMS_CLK_IDLE;                 // first leading edge in the same cycle [RULE15] [RULE9]
    r.bits_left  = char_bits(s.hold_nine);        // only data bits, no framing [RULE3]
    r.hold_full  = 1'b0;
    r.sub_tick   = 1'b0;
    r.state      = SMS_SHIFT;
    return r;
  endfunction

  // mode decode; the high-speed select has no effect in clocked mode [RULE18]
  assign master_sync = i_cfg.port_enable
                     & i_cfg.sync_mode                    // [RULE4]
                     & i_cfg.clock_source_master_select;  // [RULE5]
  assign rx_mode     = i_cfg.single_receive_enable | i_cfg.continuous_receive_enable; // [RULE6]
  assign tx_mode     = ~rx_mode;                                                     // [RULE6]
  assign may_send    = master_sync & tx_mode;                                        // [RULE2]

  // the pin inputs belong to reception and slave mode, which this block leaves out
  assign unused_pins = i_clock_line_in ^ i_data_line_in;

  // the divider only runs while a character is on the line, so no clock idles out [RULE21]
  assign gen_run = (q.state == SMS_SHIFT);

  sms_rate_gen #(
    .DIV_W (DIV_W)
  ) u_rate_gen (
    .i_clock   (i_clock),
    .i_rst     (i_rst),
    .i_run     (gen_run),
    .i_divisor (i_cfg.rate_divisor),
    .o_tick    (tick)
  );

  // every second tick ends a half bit: one clock high half, one clock low half
  assign half_edge = tick & q.sub_tick;

  // next state of the transmitter
  always_comb
  begin
    d = q;

    // tick pairing within a half bit
    if (tick)
    begin
      d.sub_tick = ~q.sub_tick;
    end

    // pin drivers follow the configuration, not software
    d.clk_oe  = master_sync;  // on for transmit and receive alike [RULE8] [RULE1]
    d.data_oe = may_send;     // off as soon as reception is set up [RULE11] [RULE2]

    if (!i_cfg.port_enable)
    begin
      // a cleared port enable acts as a reset of the whole port [RULE7]
      d = SMS_TX_RESET;
    end
    else
    begin
      case (q.state)
        SMS_IDLE:
        begin
          d.sub_tick  = 1'b0;
          d.clk_level = SMS_CLK_IDLE;          // [RULE21]
          if (q.hold_full && may_send)
          begin
            d = load_char(d);                  // empty shifter loads at once [RULE14] [RULE12]
          end
        end

        SMS_SHIFT:
        begin
          if (!may_send)
          begin
            // reception or a mode change cuts the character short; the line must not be
            // driven against a slave that is about to answer, so the partial bits are lost
            d.state     = SMS_IDLE;            // [RULE2]
            d.clk_level = SMS_CLK_IDLE;
            d.bits_left = 4'h0;
            d.sub_tick  = 1'b0;
          end
          else if (half_edge)
          begin
            if (q.clk_level != SMS_CLK_IDLE)
            begin
              // trailing edge: the slave samples here, data is not touched [RULE9]
              d.clk_level = SMS_CLK_IDLE;
              d.bits_left = q.bits_left - 4'h1; // one clock per bit [RULE10]
            end
            else if (q.bits_left == 4'h0)
            begin
              // last bit held for its full low half, the character is flushed
              if (q.hold_full)
              begin
                d = load_char(d);              // waiting character goes next [RULE13]
              end
              else
              begin
                d.state = SMS_IDLE;            // no clock beyond the data bits [RULE10] [RULE21]
              end
            end
            else
            begin
              // leading edge: next bit appears and holds for a whole bit [RULE16] [RULE9]
              d.shift_data = q.shift_data >> 1;  // lsb first [RULE20]
              d.data_level = q.shift_data[1];
              d.clk_level  = ~SMS_CLK_IDLE;
            end
          end
        end

        default:
        begin
          d = SMS_TX_RESET;
        end
      endcase

      // a software write fills the holding register; while the shifter is busy it simply
      // waits there [RULE13]. the write comes last so a write in the load cycle is kept.
      // a second write before the load replaces the waiting character.
      if (i_hold_write)
      begin
        d.hold_data = {i_cfg.nine_bit_transmit_enable & i_cfg.transmit_ninth_bit, i_hold_data}; // [RULE19]
        d.hold_nine = i_cfg.nine_bit_transmit_enable;                                         // [RULE19]
        d.hold_full = 1'b1;                                                                   // [RULE12]
      end
    end
  end

  // single state register
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      q <= SMS_TX_RESET;
    else
      q <= d;
  end

  // pin outputs come straight from flops
  assign o_clock_line.level = q.clk_level;   // master drives the shift clock [RULE1] [RULE8]
  assign o_clock_line.oe    = q.clk_oe;
  assign o_data_line.level  = q.data_level;  // [RULE11]
  assign o_data_line.oe     = q.data_oe;

  // status; the shifter contents themselves never leave the block [RULE17]
  assign o_hold_full   = q.hold_full;
  assign o_shift_empty = (q.state == SMS_IDLE);

endmodule

// File: tb/sms_slave_model.sv
`timescale 1ns/1ps
// passive slave on the far end; it only listens, so the data wire stays with the master
module sms_slave_model
(
  input  wire logic   i_sck,
  input  wire logic   i_sda,
  input  wire logic   i_clear,
  output logic [17:0] o_bits,
  output logic [4:0]  o_count
);
  // sample on the trailing edge; newest bit enters on top so the first bit lands lowest
  always @(negedge i_sck or posedge i_clear)
  begin
    if (i_clear)
    begin
      o_bits  <= 18'h00000;
      o_count <= 5'h00;
    end
    else
    begin
      o_bits  <= {i_sda, o_bits[17:1]};
      o_count <= o_count + 5'h01;
    end
  end
endmodule

// File: tb/sms_sync_tx_chk.sv
`timescale 1ns/1ps
module sms_sync_tx_chk
  import sms_pkg::*;
(
  input wire logic       i_clock,
  input wire logic       i_rst,
  input wire sms_cfg_s   i_cfg,
  input wire logic       i_hold_write,
  input wire logic [7:0] i_hold_data,
  input wire logic       i_clock_line_in,
  input wire logic       i_data_line_in,
  input wire sms_pin_s   o_clock_line,
  input wire sms_pin_s   o_data_line,
  input wire logic       o_hold_full,
  input wire logic       o_shift_empty
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic       tx_ok;
  logic [9:0] lo_q;
  // sending is allowed only as enabled synchronous master with reception off
  assign tx_ok = i_cfg.port_enable & i_cfg.sync_mode & i_cfg.clock_source_master_select
               & ~i_cfg.single_receive_enable & ~i_cfg.continuous_receive_enable;
  // length of the low phase; mid-character lows avoid the start-up slack of the divider
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      lo_q <= 10'h000;
    else
      lo_q <= o_clock_line.level ? 10'h000 : lo_q + 10'h001;
  end
  write_sets_full_a: assert property (i_hold_write && i_cfg.port_enable |=> o_hold_full)
    else $error("holding flag not set after a write");
  // a second write in the load cycle refills the holding register, so it is left out here
  start_load_a: assert property (i_hold_write && tx_ok && o_shift_empty && !o_hold_full
    ##1 tx_ok && !i_hold_write ##1 tx_ok
    |-> !o_shift_empty && o_clock_line.level && !o_hold_full) else $error("first character not loaded at once");
  idle_clock_a: assert property (o_shift_empty |-> o_clock_line.level == SMS_CLK_IDLE)
    else $error("shift clock not idle while shifter empty");
  lead_edge_a: assert property (!o_shift_empty && !$past(o_shift_empty) && $changed(o_data_line.level)
    |-> $rose(o_clock_line.level)) else $error("data changed away from a leading edge");
  bit_rate_a: assert property ($rose(o_clock_line.level) && !$past(o_shift_empty)
    |-> lo_q == 10'(SMS_TICKS_PER_HALF * (i_cfg.rate_divisor + 1))) else $error("clock low phase length wrong");
  port_off_a: assert property (!i_cfg.port_enable |=> !o_clock_line.oe && !o_data_line.oe && o_shift_empty)
    else $error("port active while disabled");
  rx_release_a: assert property (i_cfg.single_receive_enable || i_cfg.continuous_receive_enable
    |=> !o_data_line.oe) else $error("data pin driven while reception set");
  drivers_on_a: assert property (tx_ok |=> o_clock_line.oe && o_data_line.oe)
    else $error("pin drivers off in master transmit");
  cover property (i_hold_write && tx_ok && o_shift_empty);
  cover property (o_hold_full && !o_shift_empty);
  cover property (i_cfg.continuous_receive_enable && o_hold_full);
  cover property (!o_shift_empty && i_cfg.continuous_receive_enable);
endmodule

// File: tb/test_sms_sync_tx.sv
`timescale 1ns/1ps
module test_sms_sync_tx
  import sms_pkg::*;
;
  localparam sms_cfg_s TX_CFG = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01};
  logic        i_clock, i_rst, wr, clr, hold_full, shift_empty, sck, sda;
  logic [7:0]  wdata;
  sms_cfg_s    cfg, blk;
  sms_pin_s    ck_pin, dt_pin;
  logic [17:0] bits;
  logic [4:0]  cnt;
  int          fails, tests_run, cyc, n;
  // released wires: clock pulled low, data pulled high
  assign sck = ck_pin.oe ? ck_pin.level : 1'b0;
  assign sda = dt_pin.oe ? dt_pin.level : 1'b1;
  sms_sync_tx sms_sync_tx_i (.i_clock(i_clock), .i_rst(i_rst), .i_cfg(cfg), .i_hold_write(wr),
    .i_hold_data(wdata), .i_clock_line_in(sck), .i_data_line_in(sda), .o_clock_line(ck_pin),
    .o_data_line(dt_pin), .o_hold_full(hold_full), .o_shift_empty(shift_empty));
  sms_slave_model sms_slave_model_i (.i_sck(sck), .i_sda(sda), .i_clear(clr), .o_bits(bits), .o_count(cnt));
  // clock generator
  initial
  begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  task check(input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one-cycle write pulse, driven off the sampling edge
  task send(input logic [7:0] d);
    @(negedge i_clock);
    wr = 1'b1;
    wdata = d;
    @(negedge i_clock);
    wr = 1'b0;
  endtask
  // wait for the shifter to drain, then compare what the slave caught
  task expect_rx(input int nb, input logic [17:0] v);
    n = 0;
    while (!(shift_empty === 1'b1 && hold_full === 1'b0) && n < 3000)
    begin
      @(negedge i_clock);
      n++;
    end
    check(18'(n >= 3000), 18'h0);
    check(18'(cnt), 18'(nb));
    check(bits >> (18 - nb), v);
    clr = 1'b1;
    @(negedge i_clock);
    clr = 1'b0;
  endtask
  // main sequence
  initial
  begin
    cfg = '0;
    wr = 1'b0;
    wdata = 8'h00;
    clr = 1'b1;
    i_rst = 1'b1;
    repeat (10) @(negedge i_clock);
    i_rst = 1'b0;
    clr = 1'b0;
    send(8'h5a);
    @(negedge i_clock);
    check({hold_full, shift_empty, ck_pin.oe, dt_pin.oe}, 18'h4);
    cfg = TX_CFG;
    send(8'ha5);
    expect_rx(8, 18'h000a5);
    // nine-bit mode with the ninth bit set, set in one assignment
    cfg = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h01};
    send(8'h3c);
    expect_rx(9, 18'h0013c);
    cfg = TX_CFG;
    send(8'h81);
    repeat (4) @(negedge i_clock);
    send(8'h7e);
    repeat (20) @(negedge i_clock);
    check({hold_full, shift_empty}, 18'h2);
    expect_rx(16, 18'h07e81);
    // fastest divisor with the high-speed select set, which must not matter
    cfg = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00};
    send(8'h01);
    expect_rx(8, 18'h00001);
    // every blocking setting but a cleared port enable holds the character back; later writes overwrite it
    for (int k = 0; k < 4; k++)
    begin
      blk = TX_CFG;
      case (k)
        0: blk.sync_mode = 1'b0;
        1: blk.clock_source_master_select = 1'b0;
        2: blk.continuous_receive_enable = 1'b1;
        default: blk.single_receive_enable = 1'b1;
      endcase
      cfg = blk;
      send(8'(8'h10 + k));
      repeat (40) @(negedge i_clock);
      check({cnt, hold_full, dt_pin.oe}, 18'h2);
    end
    cfg = TX_CFG;
    expect_rx(8, 18'h00013);
    // reception set mid-character cuts it short, idles the clock and frees the data line
    send(8'hff);
    repeat (10) @(negedge i_clock);
    cfg.continuous_receive_enable = 1'b1;
    repeat (2) @(negedge i_clock);
    check({shift_empty, hold_full, dt_pin.oe, ck_pin.level}, 18'h8);
    // port enable dropped mid-character resets the port at once
    cfg = TX_CFG;
    send(8'hff);
    repeat (10) @(negedge i_clock);
    cfg.port_enable = 1'b0;
    repeat (2) @(negedge i_clock);
    check({shift_empty, hold_full, ck_pin.oe, dt_pin.oe}, 18'h8);
    wrap_up;
  end
  // hang guard
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc >= 20000)
    begin
      $display("wrong value at %0t: run timed out", $time);
      fails++;
      wrap_up;
    end
  end
endmodule
bind sms_sync_tx sms_sync_tx_chk sms_sync_tx_chk_i (.i_clock(i_clock), .i_rst(i_rst), .i_cfg(i_cfg),
  .i_hold_write(i_hold_write), .i_hold_data(i_hold_data), .i_clock_line_in(i_clock_line_in),
  .i_data_line_in(i_data_line_in), .o_clock_line(o_clock_line), .o_data_line(o_data_line),
  .o_hold_full(o_hold_full), .o_shift_empty(o_shift_empty));
